// [hw/cpp_top.sv]
// Overview of operation
// - the device is programmed over the four-wire test port, alone or in a daisy chain.
// - the cascade enable output is held high while programming mode is active.
// - the data and output-enable/reset outputs are released to high impedance while programming mode is active; the test-port output stays driven.
// - all non test-port pin inputs are frozen and ignored while programming mode is active; the APB bus stays live.
// - the serial variant pulses the output-enable/reset pin low when programming ends.
// - a set read lock refuses read and verify of the stored pattern.
// - a read lock alone never blocks program or erase.
// - the serial variant has one device-wide read lock cleared only by a device erase.
// - the parallel variant has one read lock per revision cleared by erasing that revision.
// - a write lock on a revision or the option area blocks program and erase there.
// - erasing a write-locked area clears its write lock.
// - an erase of a write-locked area is accepted only after the unlock instruction.
// - read and write lock together block read, program and erase of a revision.
`timescale 1ns/1ps
`default_nettype none
module cpp_top #(
  parameter logic SERIAL_ONLY = 1'b0,
  parameter int   NUM_REV     = 4,
  parameter int   DEPTH       = 32
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        TCK,
  input  wire logic        TMS,
  input  wire logic        TDI,
  output logic             TDO,
  input  wire logic        CFG_CLK,
  input  wire logic        CHIP_EN_N,
  input  wire logic        CONFIG_REQUEST_PIN_N,
  input  wire logic        OE_RST_I,
  output logic             OE_RST_O,
  output logic             OE_RST_OEN,
  input  wire logic        BUSY,
  input  wire logic        EXTERNAL_SELECT_ENABLE,
  input  wire logic [1:0]  REVISION_SELECT,
  output logic      [7:0]  DATA_O,
  output logic             DATA_OEN,
  output logic             CASCADE_ENABLE_OUT
);
  import cpp_pkg::*;

  logic [2:0]          jt_s;
  cpp_pins_type        pins_s, pins_q, pins_d;
  logic                tck_prev_q, tck_prev_d, tck_rise;
  logic [FRAME_W-1:0]  shift_q, shift_d;
  logic                tdo_q, tdo_d, armed_q, armed_d;
  logic                cmd_valid_q, cmd_valid_d, load_rd_q, load_rd_d;
  cpp_cmd_type         cmd_q, cmd_d;
  logic                st_valid;
  logic [7:0]          rdata;
  logic                rd_refused, wr_refused, unlock;
  logic [NUM_REV-1:0]  rp;
  logic [NUM_REV:0]    wp;
  logic                isp_q, isp_d, exit_fire;
  logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic                oen_q, oen_d, casc_q, casc_d, data_oen_q, data_oen_d;
  logic [CTRL_W-1:0]   ctrl_q, ctrl_d;
  logic [7:0]          dout_q, dout_d, last_rd_q, last_rd_d;
  logic                rd_seen_q, rd_seen_d, wr_seen_q, wr_seen_d;
  logic                pready_q, pready_d, pslverr_q, pslverr_d, apb_wr;
  logic [31:0]         prdata_q, prdata_d, status;

  cpp_sync #(.W(3)) u_jtag_sync (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .d      ({TCK, TMS, TDI}),
    .sync_q (jt_s)
  );

  cpp_sync #(.W(PINS_W)) u_pin_sync (
    .clk    (CORE_CLK),
    .rst_n  (RST_N),
    .d      ({CFG_CLK, CHIP_EN_N, CONFIG_REQUEST_PIN_N, OE_RST_I, BUSY,
              EXTERNAL_SELECT_ENABLE, REVISION_SELECT}),
    .sync_q (pins_s)
  );

  cpp_store #(.NUM_REV(NUM_REV), .DEPTH(DEPTH)) u_store (
    .clk          (CORE_CLK),
    .rst_n        (RST_N),
    .cmd_valid    (st_valid),
    .cmd          (cmd_q),
    .serial_only  (SERIAL_ONLY),
    .rdata_q      (rdata),
    .rd_refused_q (rd_refused),
    .wr_refused_q (wr_refused),
    .rp_q         (rp),
    .wp_q         (wp),
    .unlock_q     (unlock)
  );

  // test-port frame: tms low shifts tdi in lsb first, the first tms-high rise executes;
  // the frame register doubles as the chain path so devices can be daisy chained
  always_comb begin
    tck_rise    = jt_s[2] && !tck_prev_q;
    tck_prev_d  = jt_s[2];
    shift_d     = shift_q;
    tdo_d       = tdo_q;
    armed_d     = armed_q;
    cmd_valid_d = 1'b0;
    cmd_d       = cmd_q;
    load_rd_d   = cmd_valid_q && isp_q && cmd_q.op == OP_READ;
    if (load_rd_q) begin
      shift_d[DATA_W-1:0] = rdata;
    end
    if (tck_rise && ctrl_q[CTRL_JTAG_EN]) begin
      if (jt_s[1]) begin
        if (armed_q) begin
          cmd_valid_d = 1'b1;
          cmd_d = cpp_cmd_type'(shift_q);
          armed_d = 1'b0;
        end
      end else begin
        shift_d = {jt_s[0], shift_q[FRAME_W-1:1]};
        tdo_d = shift_q[0];
        armed_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tck_prev_q <= 1'b0;
      shift_q <= '0;
      tdo_q <= 1'b0;
      armed_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_q <= '0;
      load_rd_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_prev_d;
      shift_q <= shift_d;
      tdo_q <= tdo_d;
      armed_q <= armed_d;
      cmd_valid_q <= cmd_valid_d;
      cmd_q <= cmd_d;
      load_rd_q <= load_rd_d;
    end
  end

  // memory operations only run inside programming mode
  assign st_valid = cmd_valid_q && isp_q && cmd_q.op != OP_ISP_ENTER && cmd_q.op != OP_ISP_EXIT;

  always_comb begin
    exit_fire  = cmd_valid_q && isp_q && cmd_q.op == OP_ISP_EXIT;
    isp_d      = isp_q;
    rst_cnt_d  = (rst_cnt_q != '0) ? rst_cnt_q - 1'b1 : rst_cnt_q;
    if (cmd_valid_q && cmd_q.op == OP_ISP_ENTER) begin
      isp_d = 1'b1;
    end
    if (exit_fire) begin
      isp_d = 1'b0;
      if (SERIAL_ONLY) begin
        rst_cnt_d = RST_PULSE_LEN;
      end
    end
    oen_d      = rst_cnt_d == '0;
    casc_d     = isp_q ? 1'b1 : ctrl_q[CTRL_CASC_LVL];
    // clamp-free choice: every data pin simply floats while programming
    data_oen_d = isp_q || !ctrl_q[CTRL_DATA_OE] || pins_s.chip_en_n;
    pins_d     = isp_q ? pins_q : pins_s;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      isp_q <= 1'b0;
      rst_cnt_q <= '0;
      oen_q <= 1'b1;
      casc_q <= 1'b0;
      data_oen_q <= 1'b1;
      pins_q <= '0;
    end else begin
      isp_q <= isp_d;
      rst_cnt_q <= rst_cnt_d;
      oen_q <= oen_d;
      casc_q <= casc_d;
      data_oen_q <= data_oen_d;
      pins_q <= pins_d;
    end
  end

  // one wait state: pready rises in the second access cycle, writes land on the edge that ends it
  always_comb begin
    status                            = '0;
    status[STAT_ISP]                  = isp_q;
    status[STAT_UNLOCK]               = unlock;
    status[STAT_RP_LSB +: NUM_REV]    = rp;
    status[STAT_WP_LSB +: NUM_REV+1]  = wp;
    status[STAT_RD_REF]               = rd_seen_q;
    status[STAT_WR_REF]               = wr_seen_q;
    pready_d  = PSEL && PENABLE && !pready_q;
    apb_wr    = PSEL && PENABLE && pready_q && PWRITE;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    ctrl_d    = ctrl_q;
    dout_d    = dout_q;
    rd_seen_d = rd_seen_q;
    wr_seen_d = wr_seen_q;
    last_rd_d = load_rd_q ? rdata : last_rd_q;
    if (pready_d) begin
      prdata_d = '0;
      pslverr_d = 1'b0;
      unique case (PADDR)
        CTRL_OFS:   prdata_d[CTRL_W-1:0] = ctrl_q;
        DOUT_OFS:   prdata_d[7:0] = dout_q;
        STATUS_OFS: prdata_d = status;
        PINS_OFS:   prdata_d[PINS_W-1:0] = pins_q;
        LASTRD_OFS: prdata_d[7:0] = last_rd_q;
        default:    pslverr_d = 1'b1;
      endcase
    end
    if (apb_wr && PADDR == CTRL_OFS) begin
      ctrl_d = PWDATA[CTRL_W-1:0];
    end
    if (apb_wr && PADDR == DOUT_OFS) begin
      dout_d = PWDATA[7:0];
    end
    if (apb_wr && PADDR == STATUS_OFS && PWDATA[STAT_RD_REF]) begin
      rd_seen_d = 1'b0;
    end
    if (apb_wr && PADDR == STATUS_OFS && PWDATA[STAT_WR_REF]) begin
      wr_seen_d = 1'b0;
    end
    // a refusal in the clearing cycle must survive
    if (rd_refused) begin
      rd_seen_d = 1'b1;
    end
    if (wr_refused) begin
      wr_seen_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      ctrl_q <= CTRL_RESET;
      dout_q <= '0;
      rd_seen_q <= 1'b0;
      wr_seen_q <= 1'b0;
      last_rd_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      ctrl_q <= ctrl_d;
      dout_q <= dout_d;
      rd_seen_q <= rd_seen_d;
      wr_seen_q <= wr_seen_d;
      last_rd_q <= last_rd_d;
    end
  end

  assign PRDATA             = prdata_q;
  assign PREADY             = pready_q;
  assign PSLVERR            = pslverr_q;
  assign TDO                = tdo_q;
  assign OE_RST_O           = 1'b0;
  assign OE_RST_OEN         = oen_q;
  assign DATA_O             = dout_q;
  assign DATA_OEN           = data_oen_q;
  assign CASCADE_ENABLE_OUT = casc_q;

  logic [RST_CNT_W-1:0] low_cnt_q;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || OE_RST_OEN) low_cnt_q <= '0;
    else low_cnt_q <= low_cnt_q + 1'b1;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  property p_casc_high;
    isp_q |=> CASCADE_ENABLE_OUT;
  endproperty
  a_casc_high: assert property (p_casc_high) else $error("cascade low in programming");
  property p_data_float;
    isp_q |=> DATA_OEN;
  endproperty
  a_data_float: assert property (p_data_float) else $error("data driven in programming");
  property p_pins_frozen;
    isp_q && $past(isp_q) |-> $stable(pins_q);
  endproperty
  a_pins_frozen: assert property (p_pins_frozen) else $error("pins not frozen");
  property p_rst_start;
    exit_fire && SERIAL_ONLY |=> !OE_RST_OEN;
  endproperty
  a_rst_start: assert property (p_rst_start) else $error("reset pulse missing");
  property p_rst_len;
    $rose(OE_RST_OEN) |-> low_cnt_q == RST_PULSE_LEN;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_chain;
    tck_rise && !jt_s[1] && ctrl_q[CTRL_JTAG_EN] |=> TDO == $past(shift_q[0]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain output wrong");
  c_isp_enter: cover property ($rose(isp_q));
  c_rst_pulse: cover property ($rose(OE_RST_OEN));
endmodule
`default_nettype wire

// [include/cpp_pkg.sv]
`default_nettype none
package cpp_pkg;
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          RST_PULSE_NS     = 1000;
  localparam int          RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W        = 8;
  localparam logic [7:0]  RST_PULSE_LEN    = RST_CNT_W'(RST_PULSE_CYCLES);

  localparam int          FRAME_W          = 20;
  localparam int          AREA_W           = 3;
  localparam int          ADDR_W           = 5;
  localparam int          DATA_W           = 8;
  localparam logic [2:0]  OPT_AREA         = 3'h4;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;

  localparam logic [11:0] CTRL_OFS         = 12'h000;
  localparam logic [11:0] DOUT_OFS         = 12'h004;
  localparam logic [11:0] STATUS_OFS       = 12'h008;
  localparam logic [11:0] PINS_OFS         = 12'h00C;
  localparam logic [11:0] LASTRD_OFS       = 12'h010;

  localparam int          CTRL_W           = 3;
  localparam int          CTRL_JTAG_EN     = 0;
  localparam int          CTRL_DATA_OE     = 1;
  localparam int          CTRL_CASC_LVL    = 2;
  localparam logic [2:0]  CTRL_RESET       = 3'h1;

  localparam int          STAT_ISP         = 0;
  localparam int          STAT_UNLOCK      = 1;
  localparam int          STAT_RP_LSB      = 4;
  localparam int          STAT_WP_LSB      = 8;
  localparam int          STAT_RD_REF      = 16;
  localparam int          STAT_WR_REF      = 17;

  typedef enum logic [3:0] {
    OP_NOP          = 4'h0,
    OP_ISP_ENTER    = 4'h1,
    OP_ISP_EXIT     = 4'h2,
    OP_AREA_ERASE   = 4'h3,
    OP_PROGRAM      = 4'h4,
    OP_READ         = 4'h5,
    OP_SET_RP       = 4'h6,
    OP_SET_WP       = 4'h7,
    OP_ERASE_UNLOCK = 4'h8
  } cpp_op_type;

  typedef struct packed {
    cpp_op_type  op;
    logic [2:0]  area;
    logic [4:0]  addr;
    logic [7:0]  data;
  } cpp_cmd_type;

  typedef struct packed {
    logic        cfg_clk;
    logic        chip_en_n;
    logic        config_request_pin_n;
    logic        oe_rst;
    logic        busy;
    logic        external_select_enable;
    logic [1:0]  revision_select;
  } cpp_pins_type;

  localparam int          PINS_W           = $bits(cpp_pins_type);
endpackage
`default_nettype wire

// [hw/cpp_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
endmodule
`default_nettype wire

// [hw/cpp_store.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_store #(
  parameter int NUM_REV = 4,
  parameter int DEPTH   = 32
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cmd_valid,
  input  wire cpp_pkg::cpp_cmd_type cmd,
  input  wire logic                serial_only,
  output logic [7:0]               rdata_q,
  output logic                     rd_refused_q,
  output logic                     wr_refused_q,
  output logic [NUM_REV-1:0]       rp_q,
  output logic [NUM_REV:0]         wp_q,
  output logic                     unlock_q
);
  import cpp_pkg::*;
  localparam int REV_W = $clog2(NUM_REV);
  localparam int IDX_W = REV_W + ADDR_W;

  logic [7:0]         mem [NUM_REV*DEPTH];
  logic [7:0]         opt_q, opt_d, rdata_d;
  logic               rd_refused_d, wr_refused_d, unlock_d;
  logic [NUM_REV-1:0] rp_d;
  logic [NUM_REV:0]   wp_d;
  logic [REV_W-1:0]   rev;
  logic [IDX_W-1:0]   idx;
  logic               valid_rev, is_opt, in_wp, rp_hit, wp_hit;
  logic               erase_all, erase_rev, prog_we;

  always_comb begin
    rev       = cmd.area[REV_W-1:0];
    idx       = {rev, cmd.addr};
    valid_rev = 32'(cmd.area) < NUM_REV;
    is_opt    = cmd.area == OPT_AREA;
    in_wp     = valid_rev || is_opt;
    // single device-wide read lock on the serial variant
    rp_hit    = serial_only ? rp_q[0] : (valid_rev && rp_q[rev]);
    wp_hit    = !serial_only && in_wp && wp_q[cmd.area];
    rdata_d = rdata_q;
    rd_refused_d = 1'b0;
    wr_refused_d = 1'b0;
    opt_d = opt_q;
    rp_d = rp_q;
    wp_d = wp_q;
    unlock_d = unlock_q;
    erase_all = 1'b0;
    erase_rev = 1'b0;
    prog_we = 1'b0;
    if (cmd_valid) begin
      unique case (cmd.op)
        OP_READ: begin
          if (rp_hit) begin
            rd_refused_d = 1'b1;
            rdata_d = '0;
          end else if (valid_rev) begin
            rdata_d = mem[idx];
          end else if (is_opt) begin
            rdata_d = opt_q;
          end else begin
            rd_refused_d = 1'b1;
            rdata_d = '0;
          end
        end
        OP_PROGRAM: begin
          // read lock alone never stops writing
          if (wp_hit || !in_wp) begin
            wr_refused_d = 1'b1;
          end else if (valid_rev) begin
            prog_we = 1'b1;
          end else begin
            opt_d = opt_q & cmd.data;
          end
        end
        OP_AREA_ERASE: begin
          if ((wp_hit && !unlock_q) || !in_wp) begin
            wr_refused_d = 1'b1;
          end else begin
            unlock_d = 1'b0;
            if (serial_only) begin
              erase_all = 1'b1;
              rp_d = '0;
            end else if (valid_rev) begin
              erase_rev = 1'b1;
              rp_d[rev] = 1'b0;
              wp_d[cmd.area] = 1'b0;
            end else begin
              opt_d = ERASED_BYTE;
              wp_d[OPT_AREA] = 1'b0;
            end
          end
        end
        OP_SET_RP: begin
          if (wp_hit || !valid_rev) begin
            wr_refused_d = 1'b1;
          end else begin
            rp_d[serial_only ? '0 : rev] = 1'b1;
          end
        end
        OP_SET_WP: begin
          if (serial_only || !in_wp) begin
            wr_refused_d = 1'b1;
          end else begin
            wp_d[cmd.area] = 1'b1;
          end
        end
        OP_ERASE_UNLOCK: unlock_d = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
      rd_refused_q <= 1'b0;
      wr_refused_q <= 1'b0;
      opt_q <= ERASED_BYTE;
      rp_q <= '0;
      wp_q <= '0;
      unlock_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_refused_q <= rd_refused_d;
      wr_refused_q <= wr_refused_d;
      opt_q <= opt_d;
      rp_q <= rp_d;
      wp_q <= wp_d;
      unlock_q <= unlock_d;
    end
  end

  // flash cells only clear on program; erase is the only way back to ones
  always_ff @(posedge clk) begin
    if (erase_all) begin
      for (int i = 0; i < NUM_REV*DEPTH; i++) mem[i] <= ERASED_BYTE;
    end else if (erase_rev) begin
      for (int j = 0; j < DEPTH; j++) mem[{rev, ADDR_W'(j)}] <= ERASED_BYTE;
    end else if (prog_we) begin
      mem[idx] <= mem[idx] & cmd.data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_read_locked;
    cmd_valid && cmd.op == OP_READ && rp_hit |=> rd_refused_q && rdata_q == 8'h00;
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("locked read leaked data");
  property p_prog_rp_only;
    cmd_valid && cmd.op == OP_PROGRAM && valid_rev && !wp_hit |=> !wr_refused_q;
  endproperty
  a_prog_rp_only: assert property (p_prog_rp_only) else $error("program refused");
  property p_serial_erase;
    cmd_valid && cmd.op == OP_AREA_ERASE && serial_only && in_wp |=> rp_q == '0 && !wr_refused_q;
  endproperty
  a_serial_erase: assert property (p_serial_erase) else $error("erase kept read lock");
  property p_rev_erase;
    cmd_valid && cmd.op == OP_AREA_ERASE && !serial_only && valid_rev && !wp_hit
      |=> (rp_q & ~$past(rp_q)) == '0 && rp_q <= $past(rp_q) && !wr_refused_q;
  endproperty
  a_rev_erase: assert property (p_rev_erase) else $error("revision erase failed");
  property p_wp_prog;
    cmd_valid && cmd.op == OP_PROGRAM && wp_hit |=> wr_refused_q;
  endproperty
  a_wp_prog: assert property (p_wp_prog) else $error("program on locked area");
  property p_locked_erase;
    cmd_valid && cmd.op == OP_AREA_ERASE && wp_hit && !unlock_q
      |=> wr_refused_q && $stable(wp_q) && $stable(rp_q) && $stable(opt_q);
  endproperty
  a_locked_erase: assert property (p_locked_erase) else $error("locked erase acted");
  property p_unlocked_erase;
    cmd_valid && cmd.op == OP_AREA_ERASE && wp_hit && unlock_q
      |=> !wr_refused_q && !unlock_q && wp_q < $past(wp_q);
  endproperty
  a_unlocked_erase: assert property (p_unlocked_erase) else $error("erase kept lock");
  property p_both_locks;
    cmd_valid && rp_hit && wp_hit && (cmd.op == OP_READ || cmd.op == OP_PROGRAM)
      |=> rd_refused_q || wr_refused_q;
  endproperty
  a_both_locks: assert property (p_both_locks) else $error("dual lock bypassed");
  c_unlocked_erase: cover property (cmd_valid && cmd.op == OP_AREA_ERASE && wp_hit && unlock_q);
  c_read_locked: cover property (cmd_valid && cmd.op == OP_READ && rp_hit);
endmodule
`default_nettype wire

// [bench/cpp_prog.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_prog (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tdo is taken just before the next rise, long after the last shift settled
  task automatic cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #390 o = tdo;
    #10 tck = 1'b1;
    #400 tck = 1'b0;
  endtask
  // tck stands low between frames; idle tdi shows the inverse of the last bit
  task automatic frame(input logic [19:0] f, output logic [19:0] prev);
    logic o;
    for (int i = 0; i < 20; i++) begin
      cyc(1'b0, f[i], o);
      if (i > 0) prev[i-1] = o;
    end
    cyc(1'b1, ~f[19], o);
    prev[19] = o;
  endtask
endmodule
`default_nettype wire

// [bench/cpp_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cpp_top_tb;
  import cpp_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic  [11:0] paddr = 12'h000;
  logic  [31:0] pwdata = 32'h0000_0000;
  cpp_pins_type pins = cpp_pins_type'(8'h00);
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, tck, tms, tdi, tdo, oe_o, oe_oen, oe_w, doen, casc, oen_s;
  wire logic [7:0]  data_o;
  int           n_mismatch = 0;
  int           checks = 0;
  logic  [31:0] rd;
  logic         er;
  logic  [19:0] sh;
  always #50 clk = ~clk;
  assign oe_w = oe_oen ? pins.oe_rst : oe_o;
  cpp_top #(.SERIAL_ONLY(1'b0), .NUM_REV(4), .DEPTH(32)) u_dut (.CORE_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TDO(tdo), .CFG_CLK(pins.cfg_clk), .CHIP_EN_N(pins.chip_en_n),
    .CONFIG_REQUEST_PIN_N(pins.config_request_pin_n), .OE_RST_I(oe_w), .OE_RST_O(oe_o),
    .OE_RST_OEN(oe_oen), .BUSY(pins.busy), .EXTERNAL_SELECT_ENABLE(pins.external_select_enable),
    .REVISION_SELECT(pins.revision_select), .DATA_O(data_o), .DATA_OEN(doen),
    .CASCADE_ENABLE_OUT(casc));
  // serial variant on the same bus and link, watched only for its reset pulse
  cpp_top #(.SERIAL_ONLY(1'b1), .NUM_REV(4), .DEPTH(32)) u_dut_s (.CORE_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(),
    .PREADY(), .PSLVERR(), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(), .CFG_CLK(pins.cfg_clk),
    .CHIP_EN_N(pins.chip_en_n), .CONFIG_REQUEST_PIN_N(pins.config_request_pin_n),
    .OE_RST_I(pins.oe_rst), .OE_RST_O(), .OE_RST_OEN(oen_s), .BUSY(pins.busy),
    .EXTERNAL_SELECT_ENABLE(pins.external_select_enable), .REVISION_SELECT(pins.revision_select),
    .DATA_O(), .DATA_OEN(), .CASCADE_ENABLE_OUT());
  cpp_prog u_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      give_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rg(input logic [11:0] a, input logic [31:0] m, e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd & m, e);
  endtask
  task automatic fr(input cpp_op_type op, input logic [2:0] ar, input logic [4:0] ad,
                    input logic [7:0] d);
    // link edges land on falling core clock edges, between rising ones
    @(negedge clk);
    u_prog.frame({op, ar, ad, d}, sh);
  endtask
  task automatic mem(input logic [2:0] ar, input logic [4:0] ad, input logic [7:0] e, input string nm);
    fr(OP_READ, ar, ad, 8'h00);
    fr(OP_NOP, 3'h0, 5'h00, 8'h00);
    chk(nm, {24'h00_0000, sh[7:0]}, {24'h00_0000, e});
  endtask
  task automatic t_reset();
    chk("casc", casc, 1'b0);
    chk("doen", doen, 1'b1);
    rg(CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0001, "ctrl");
    rg(STATUS_OFS, 32'h0003_1FF3, 32'h0000_0000, "status");
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("slverr", er, 1'b1);
    apb(1'b1, DOUT_OFS, 32'h0000_005A);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    pins <= cpp_pins_type'(8'hA5);
    repeat (6) @(posedge clk);
    chk("dout", {doen, data_o}, 9'h05A);
    rg(PINS_OFS, 32'h0000_00FF, 32'h0000_00A5, "pins");
    $display("t_reset done");
  endtask
  task automatic t_isp();
    fr(OP_ISP_ENTER, 3'h0, 5'h00, 8'h00);
    // sync, execute and output flops trail the executing edge
    repeat (3) @(posedge clk);
    chk("casc_isp", casc, 1'b1);
    chk("doen_isp", {doen, oe_oen}, 2'h3);
    pins <= cpp_pins_type'(8'h5A);
    repeat (6) @(posedge clk);
    rg(PINS_OFS, 32'h0000_00FF, 32'h0000_00A5, "pins_isp");
    fr(OP_AREA_ERASE, 3'h0, 5'h00, 8'h00);
    fr(OP_PROGRAM, 3'h0, 5'h03, 8'hA5);
    mem(3'h0, 5'h03, 8'hA5, "prog");
    $display("t_isp done");
  endtask
  task automatic t_rlock();
    fr(OP_SET_RP, 3'h0, 5'h00, 8'h00);
    mem(3'h0, 5'h03, 8'h00, "rd_lock");
    rg(STATUS_OFS, 32'h0003_0010, 32'h0001_0010, "rp_stat");
    apb(1'b1, STATUS_OFS, 32'h0003_0000);
    fr(OP_PROGRAM, 3'h0, 5'h03, 8'h0F);
    rg(STATUS_OFS, 32'h0002_0000, 32'h0000_0000, "wr_ok");
    fr(OP_AREA_ERASE, 3'h0, 5'h00, 8'h00);
    rg(STATUS_OFS, 32'h0000_0010, 32'h0000_0000, "rp_clr");
    $display("t_rlock done");
  endtask
  task automatic t_wlock();
    fr(OP_AREA_ERASE, 3'h1, 5'h00, 8'h00);
    fr(OP_PROGRAM, 3'h1, 5'h00, 8'h3C);
    fr(OP_SET_WP, 3'h1, 5'h00, 8'h00);
    fr(OP_PROGRAM, 3'h1, 5'h00, 8'h00);
    rg(STATUS_OFS, 32'h0002_0200, 32'h0002_0200, "wp_prog");
    fr(OP_AREA_ERASE, 3'h1, 5'h00, 8'h00);
    mem(3'h1, 5'h00, 8'h3C, "wp_keep");
    fr(OP_ERASE_UNLOCK, 3'h0, 5'h00, 8'h00);
    rg(STATUS_OFS, 32'h0000_0202, 32'h0000_0202, "unlock");
    fr(OP_AREA_ERASE, 3'h1, 5'h00, 8'h00);
    rg(STATUS_OFS, 32'h0000_0202, 32'h0000_0000, "wp_clr");
    fr(OP_SET_RP, 3'h2, 5'h00, 8'h00);
    fr(OP_SET_WP, 3'h2, 5'h00, 8'h00);
    apb(1'b1, STATUS_OFS, 32'h0003_0000);
    fr(OP_PROGRAM, 3'h2, 5'h00, 8'h00);
    mem(3'h2, 5'h00, 8'h00, "both");
    rg(STATUS_OFS, 32'h0003_0000, 32'h0003_0000, "both_st");
    fr(OP_ISP_EXIT, 3'h0, 5'h00, 8'h00);
    repeat (6) @(posedge clk);
    // chip enable pin is high here, so data stays released; only the serial part pulses
    chk("exit", {casc, doen, oe_oen, oen_s}, 4'h6);
    repeat (5) @(posedge clk);
    chk("rst_end", oen_s, 1'b1);
    $display("t_wlock done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_isp();
    t_rlock();
    t_wlock();
    give_verdict();
  end
endmodule
`default_nettype wire
